// file: hdl/sf_block.v
// generic special-function block: latch, launched timer, up/down counter, analogue scaling
// assumes APB from software, signal inputs from pins, one 125 MHz clock
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sf_block_map.vh"

module sf_block #(
    parameter integer SCAN_CYCLES = `SCAN_NS / `CLK_PERIOD_NS,
    parameter integer TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // signal inputs, asynchronous pins
    input  wire [7:0]  in_pins,
    input  wire        power_ok,
    input  wire [15:0] analogue_in_pin,
    // on-unit parameter panel
    input  wire        panel_wr,
    input  wire [15:0] panel_wdata,
    output reg  [15:0] panel_view,
    output reg         panel_refused,
    // block outputs
    output reg         q,
    output reg  [15:0] count,
    output reg  [31:0] scaled_value
);

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function [15:0] clamp16;
        input signed [15:0] v;
        input signed [15:0] lim;
        begin
            if (v > lim) begin
                clamp16 = lim;
            end else if (v < -lim) begin
                clamp16 = -lim;
            end else begin
                clamp16 = v;
            end
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            case (a)
                `OFS_CTRL, `OFS_TIME, `OFS_GAIN, `OFS_OFFSET, `OFS_STATUS,
                `OFS_COUNT, `OFS_ELAPSED, `OFS_SCALED, `OFS_INTERNAL: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------------
    reg  [31:0] ctrl;
    reg  [15:0] time_par;
    reg  [15:0] gain;
    reg  [15:0] offset;
    reg  [7:0]  sync1;
    reg  [7:0]  sync2;
    reg  [1:0]  pwr_sync;
    reg         pwr_prev;
    reg  [15:0] ain1;
    reg  [15:0] ain2;
    reg  [7:0]  prev_in;
    reg  [31:0] scan_cnt;
    reg  [31:0] tick_cnt;
    reg  [12:0] pre_cnt;
    reg  [15:0] elapsed;
    reg         latch;
    reg         run;
    reg         done;
    reg  [9:0]  internal_value;

    wire [9:0]  scale_internal;
    wire [31:0] scale_value;
    wire [7:0]  eff_in;
    wire        scan;
    wire        tick;
    wire        wr_en;
    wire        protect;
    wire        keep;
    wire        pwr_on;
    wire [1:0]  tbase;
    wire [15:0] minor_max;
    wire [15:0] target;
    wire [12:0] pre_max;
    wire [15:0] next_time;
    reg  [15:0] next_count;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign wr_en   = psel & penable & pwrite & pready & mapped(paddr);
    assign protect = ctrl[`CTRL_PROTECT];
    assign keep    = ctrl[`CTRL_RETAIN] | ctrl[`CTRL_ALWAYS];
    assign tbase   = ctrl[`CTRL_TB_HI:`CTRL_TB_LO];
    assign pwr_on  = pwr_sync[1];
    assign scan    = (scan_cnt == SCAN_CYCLES - 1);
    assign tick    = (tick_cnt == TICK_CYCLES - 1);
    assign eff_in  = sync2 ^ ctrl[`CTRL_INV_HI:`CTRL_INV_LO];

    // ----------------------------------------------------------------------
    // time base decode
    // ----------------------------------------------------------------------
    // an undefined time base code behaves as seconds
    assign minor_max = (tbase == `TB_MIN || tbase == `TB_HOUR) ?
                       {8'h00, `MINOR_MAX_SIX} : {8'h00, `MINOR_MAX_SEC};
    assign pre_max   = (tbase == `TB_MIN)  ? `PRE_MIN :
                       (tbase == `TB_HOUR) ? `PRE_HOUR : `PRE_SEC;
    assign target    = time_par[`TIME_MAJ_HI:`TIME_MAJ_LO] *
                       ((tbase == `TB_MIN || tbase == `TB_HOUR) ? `MUL_SIX : `MUL_SEC)
                       + {8'h00, time_par[`TIME_MIN_HI:`TIME_MIN_LO]};

    // minor field limited to the chosen base: 99 hundredths or 59 s/min
    function [15:0] fit_time;
        input [15:0] v;
        input [15:0] mmax;
        begin
            if ({8'h00, v[`TIME_MIN_HI:`TIME_MIN_LO]} > mmax) begin
                fit_time = {v[`TIME_MAJ_HI:`TIME_MAJ_LO], mmax[7:0]};
            end else begin
                fit_time = v;
            end
        end
    endfunction

    assign next_time = fit_time(pwdata[15:0], minor_max);

    // ----------------------------------------------------------------------
    // scaling datapath
    // ----------------------------------------------------------------------
    sf_scale u_scale (
        .raw      (ain2),
        .gain     (gain),
        .offset   (offset),
        .internal (scale_internal),
        .value    (scale_value)
    );

    // ----------------------------------------------------------------------
    // synchronisers and time-base counters
    // ----------------------------------------------------------------------
    // the analogue word may tear while changing; it is only used at scan
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1    <= 8'h00;
            sync2    <= 8'h00;
            pwr_sync <= 2'h0;
            ain1     <= 16'h0000;
            ain2     <= 16'h0000;
            scan_cnt <= 32'h0000_0000;
            tick_cnt <= 32'h0000_0000;
        end else begin
            sync1    <= in_pins;
            sync2    <= sync1;
            pwr_sync <= {pwr_sync[0], power_ok};
            ain1     <= analogue_in_pin;
            ain2     <= ain1;
            scan_cnt <= scan ? 32'h0000_0000 : scan_cnt + 32'h0000_0001;
            tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------------
    // register file and panel
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl          <= `CTRL_RESET;
            time_par      <= `TIME_RESET;
            gain          <= `GAIN_RESET;
            offset        <= `OFFSET_RESET;
            prdata        <= 32'h0000_0000;
            panel_view    <= 16'h0000;
            panel_refused <= 1'b0;
        end else begin
            panel_refused <= 1'b0;
            // the bus is the configuration tool; it may always write
            if (wr_en) begin
                case (paddr)
                    `OFS_CTRL:   ctrl     <= {16'h0000, pwdata[15:8], 3'h0, pwdata[4:0]};
                    `OFS_TIME:   time_par <= next_time;
                    `OFS_GAIN:   gain     <= clamp16(pwdata[15:0], `GAIN_LIM);
                    `OFS_OFFSET: offset   <= clamp16(pwdata[15:0], `OFFSET_LIM);
                    default: begin
                    end
                endcase
            end else if (panel_wr) begin
                if (protect) begin
                    panel_refused <= 1'b1;
                end else begin
                    time_par <= fit_time(panel_wdata, minor_max);
                end
            end
            panel_view <= protect ? 16'h0000 : time_par;
            if (psel & ~penable & ~pwrite) begin
                case (paddr)
                    `OFS_CTRL:     prdata <= ctrl;
                    `OFS_TIME:     prdata <= {16'h0000, time_par};
                    `OFS_GAIN:     prdata <= {{16{gain[15]}}, gain};
                    `OFS_OFFSET:   prdata <= {{16{offset[15]}}, offset};
                    `OFS_STATUS:   prdata <= {27'h0, pwr_on, done, run, latch, q};
                    `OFS_COUNT:    prdata <= {16'h0000, count};
                    `OFS_ELAPSED:  prdata <= {16'h0000, elapsed};
                    `OFS_SCALED:   prdata <= scaled_value;
                    `OFS_INTERNAL: prdata <= {22'h0, internal_value};
                    default:       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------------
    // block function
    // ----------------------------------------------------------------------
    always @* begin
        next_count = count;
        if (eff_in[`IN_PULSE] & ~prev_in[`IN_PULSE]) begin
            next_count = eff_in[`IN_DIR] ? count - 16'h0001 : count + 16'h0001;
        end
    end

    // state freezes while power is absent; without retention it restarts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_prev       <= 1'b0;
            prev_in        <= 8'h00;
            pre_cnt        <= 13'h0000;
            elapsed        <= 16'h0000;
            latch          <= 1'b0;
            run            <= 1'b0;
            done           <= 1'b0;
            q              <= 1'b0;
            count          <= 16'h0000;
            scaled_value   <= 32'h0000_0000;
            internal_value <= 10'h000;
        end else begin
            pwr_prev <= pwr_on;
            if (pwr_on & ~pwr_prev & ~keep) begin
                pre_cnt <= 13'h0000;
                elapsed <= 16'h0000;
                latch   <= 1'b0;
                run     <= 1'b0;
                done    <= 1'b0;
                q       <= 1'b0;
                count   <= 16'h0000;
                prev_in <= 8'h00;
            end else if (pwr_on) begin
                if (scan) begin
                    prev_in        <= eff_in;
                    scaled_value   <= scale_value;
                    internal_value <= scale_internal;
                    if (eff_in[`IN_KILL] | eff_in[`IN_CLEAR]) begin
                        pre_cnt <= 13'h0000;
                        elapsed <= 16'h0000;
                        latch   <= 1'b0;
                        run     <= 1'b0;
                        done    <= 1'b0;
                        count   <= 16'h0000;
                        q       <= eff_in[`IN_KILL] ? 1'b0 :
                                   eff_in[`IN_FLIP] & eff_in[`IN_GATE];
                    end else if (eff_in[`IN_GATE]) begin
                        count <= next_count;
                        if (eff_in[`IN_SET]) begin
                            latch <= 1'b1;
                        end
                        if (eff_in[`IN_LAUNCH] & ~prev_in[`IN_LAUNCH]) begin
                            run     <= 1'b1;
                            done    <= 1'b0;
                            elapsed <= 16'h0000;
                            pre_cnt <= 13'h0000;
                        end
                        q <= (eff_in[`IN_SET] | latch | done) ^ eff_in[`IN_FLIP];
                    end
                end else if (tick & run & eff_in[`IN_GATE] & ~eff_in[`IN_KILL]) begin
                    // timer advances on the common tick, seen at the next scan
                    if (pre_cnt == pre_max - 13'h0001) begin
                        pre_cnt <= 13'h0000;
                        if (elapsed + 16'h0001 >= target) begin
                            run  <= 1'b0;
                            done <= 1'b1;
                        end
                        elapsed <= elapsed + 16'h0001;
                    end else begin
                        pre_cnt <= pre_cnt + 13'h0001;
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: hdl/sf_block_map.vh
// offsets, field positions, reset values and timing constants of the special-function block
// assumes a 125 MHz pclk and an 8-bit APB byte address
`ifndef SF_BLOCK_MAP_VH
`define SF_BLOCK_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_TIME        8'h04
`define OFS_GAIN        8'h08
`define OFS_OFFSET      8'h0c
`define OFS_STATUS      8'h10
`define OFS_COUNT       8'h14
`define OFS_ELAPSED     8'h18
`define OFS_SCALED      8'h1c
`define OFS_INTERNAL    8'h20

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_RETAIN     0
`define CTRL_ALWAYS     1
`define CTRL_PROTECT    2
`define CTRL_TB_LO      3
`define CTRL_TB_HI      4
`define CTRL_INV_LO     8
`define CTRL_INV_HI     15
`define CTRL_RESET      32'h0000_0000

// time base codes
`define TB_SEC          2'h0
`define TB_MIN          2'h1
`define TB_HOUR         2'h2

// time parameter fields: major in [15:8], minor in [7:0]
`define TIME_MAJ_HI     15
`define TIME_MAJ_LO     8
`define TIME_MIN_HI     7
`define TIME_MIN_LO     0
`define TIME_RESET      16'h0000
`define MINOR_MAX_SEC   8'h63
`define MINOR_MAX_SIX   8'h3b
`define MUL_SEC         16'h0064
`define MUL_SIX         16'h003c

// ticks of 10 ms per minor unit for each time base
`define PRE_SEC         13'h0001
`define PRE_MIN         13'h0064
`define PRE_HOUR        13'h1770

// ----------------------------------------------------------------------
// signal input positions
// ----------------------------------------------------------------------
`define IN_SET          0
`define IN_KILL         1
`define IN_LAUNCH       2
`define IN_PULSE        3
`define IN_DIR          4
`define IN_GATE         5
`define IN_FLIP         6
`define IN_CLEAR        7
`define IN_COUNT        8

// status register fields
`define ST_Q            0
`define ST_LATCH        1
`define ST_RUN          2
`define ST_DONE         3
`define ST_POWER        4

// ----------------------------------------------------------------------
// analogue scaling
// ----------------------------------------------------------------------
`define AIN_FULL        16'h03e8
`define GAIN_LIM        16'h03e8
`define OFFSET_LIM      16'h2710
`define GAIN_RESET      16'h0064
`define OFFSET_RESET    16'h0000
`define SCALE_DIV       27'h0000064

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   8
`define TICK_NS         10000000
`define SCAN_NS         1000000

`endif

// file: hdl/sf_scale.v
// analogue scaling datapath: saturate to 0..1000, times gain in hundredths, plus offset
// purely combinational; the caller registers the result once per scan
`timescale 1ns/1ps
`default_nettype none
`include "sf_block_map.vh"

module sf_scale (
    // analogue reading, units of 10 mV
    input  wire        [15:0] raw,
    // scaling parameters, already limited to their ranges
    input  wire signed [15:0] gain,
    input  wire signed [15:0] offset,
    // results
    output wire        [9:0]  internal,
    output wire signed [31:0] value
);

    wire               over;
    wire        [15:0] full;
    wire signed [26:0] prod;
    wire        [26:0] mag;
    wire        [26:0] quot;
    wire        [26:0] trunc;

    assign full     = `AIN_FULL;
    assign over     = (raw > full);
    assign internal = over ? full[9:0] : raw[9:0];

    // hundredths dropped toward zero before the offset goes in
    assign prod  = $signed({1'b0, internal}) * gain;
    assign mag   = prod[26] ? (~prod + 27'h0000001) : prod;
    assign quot  = mag / `SCALE_DIV;
    assign trunc = prod[26] ? (~quot + 27'h0000001) : quot;
    assign value = $signed({{5{trunc[26]}}, trunc}) + $signed({{16{offset[15]}}, offset});

endmodule

`default_nettype wire

// file: tb/sf_block_assertions.sv
// checker for sf_block: kill and clear, gate freeze, power freeze, panel guard, gain limit
// assumes it is bound to sf_block and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "sf_block_map.vh"

module sf_block_checker #(
    parameter integer SCAN_CYCLES = 16,
    parameter integer TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // pins and panel
    input wire logic [7:0]  in_pins,
    input wire logic        power_ok,
    input wire logic        panel_wr,
    input wire logic [15:0] panel_view,
    input wire logic        panel_refused,
    // block outputs
    input wire logic        q,
    input wire logic [15:0] count
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // shadow of control fields and hold counters
    // ----------------------------------------------------------------
    logic        prot;
    logic [7:0]  inv;
    logic [15:0] kill_n;
    logic [15:0] clr_n;
    logic [15:0] gate_n;
    logic [15:0] off_n;
    wire  [7:0]  eff    = in_pins ^ inv;
    wire         apb_wr = psel && penable && pwrite;

    function automatic logic [15:0] bump(input logic [15:0] c);
        bump = (c == 16'hffff) ? c : c + 16'h0001;
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot   <= 1'b0;
            inv    <= 8'h00;
            kill_n <= 16'h0000;
            clr_n  <= 16'h0000;
            gate_n <= 16'h0000;
            off_n  <= 16'h0000;
        end else begin
            if (apb_wr && paddr == `OFS_CTRL) begin
                prot <= pwdata[`CTRL_PROTECT];
                inv  <= pwdata[`CTRL_INV_HI:`CTRL_INV_LO];
            end
            kill_n <= (eff[`IN_KILL] && power_ok) ? bump(kill_n) : 16'h0000;
            clr_n  <= (eff[`IN_CLEAR] && power_ok) ? bump(clr_n) : 16'h0000;
            // gate low only counts while nothing else may move the state
            gate_n <= (!eff[`IN_GATE] && !eff[`IN_KILL] && !eff[`IN_CLEAR] && power_ok)
                      ? bump(gate_n) : 16'h0000;
            off_n  <= power_ok ? 16'h0000 : bump(off_n);
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_wr_hidden;
        panel_wr && prot && !apb_wr;
    endsequence
    sequence s_rd_gain;
        psel && !penable && !pwrite && paddr == `OFS_GAIN ##1 psel && penable;
    endsequence

    a_kill_q_low: assert property (kill_n > SCAN_CYCLES + 3 |-> !q && count == 16'h0000)
        else $error("output or count not cleared under kill");
    a_clear_count_zero: assert property (clr_n > SCAN_CYCLES + 3 |-> count == 16'h0000)
        else $error("count not cleared under clear-all");
    a_gate_freeze: assert property (gate_n > 5 |-> $stable(q) && $stable(count))
        else $error("block state moved with gate low");
    a_power_freeze: assert property (off_n > 4 |-> $stable(q) && $stable(count))
        else $error("block state moved without power");
    a_view_hidden: assert property (prot && $past(prot) |-> panel_view == 16'h0000)
        else $error("protected time shown on panel");
    a_refuse_guard: assert property (s_wr_hidden |=> panel_refused)
        else $error("protected panel edit not refused");
    a_refuse_cause: assert property (panel_refused |-> $past(panel_wr) && $past(prot))
        else $error("panel refusal without protected edit");
    a_gain_limit: assert property (s_rd_gain |->
        $signed(prdata) <= 1000 && $signed(prdata) >= -1000)
        else $error("gain read outside its range");
endmodule

bind sf_block sf_block_checker #(
    .SCAN_CYCLES(SCAN_CYCLES),
    .TICK_CYCLES(TICK_CYCLES)
) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .in_pins(in_pins),
    .power_ok(power_ok), .panel_wr(panel_wr), .panel_view(panel_view),
    .panel_refused(panel_refused), .q(q), .count(count)
);
`default_nettype wire

// file: tb/sf_pin_model.sv
// physical inputs in front of sf_block: signal pins, analogue word, supply monitor
// assumes the bench names wanted levels; they reach the pins after a rising edge
`timescale 1ns/1ps
`default_nettype none

module sf_pin_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // wanted levels
    input  wire logic [7:0]  want_pins,
    input  wire logic [15:0] want_ain,
    input  wire logic        want_pwr,
    // controller inputs
    output logic      [7:0]  in_pins,
    output logic      [15:0] analogue_in_pin,
    output logic             power_ok
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_pins         <= 8'h00;
            analogue_in_pin <= 16'h0000;
            power_ok        <= 1'b1;
        end else begin
            in_pins         <= want_pins;
            analogue_in_pin <= want_ain;
            power_ok        <= want_pwr;
        end
    end
endmodule
`default_nettype wire

// file: tb/sf_block_tb_top.sv
// self-checking bench for sf_block: apb registers, pins, timer, scaling, panel
// assumes short scan and tick counts; expectations come from the bench's own model
`timescale 1ns/1ps
`default_nettype none
`include "sf_block_map.vh"

module sf_block_tb_top;
    localparam int SCAN = 16;
    localparam int TICK = 5;
    logic        pclk, presetn, psel, penable, pwrite, panel_wr, want_pwr, err;
    logic        pready, pslverr, power_ok, panel_refused, q;
    logic [7:0]  paddr, want_pins, in_pins;
    logic [15:0] want_ain, ain, panel_wdata, panel_view, count;
    logic [31:0] pwdata, prdata, scaled_value, rd;
    int          err_count, checks, n, a, g, o, exp_cnt;

    sf_pin_model src (.pclk(pclk), .presetn(presetn), .want_pins(want_pins),
        .want_ain(want_ain), .want_pwr(want_pwr), .in_pins(in_pins),
        .analogue_in_pin(ain), .power_ok(power_ok));
    sf_block #(.SCAN_CYCLES(SCAN), .TICK_CYCLES(TICK)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_pins(in_pins),
        .power_ok(power_ok), .analogue_in_pin(ain), .panel_wr(panel_wr),
        .panel_wdata(panel_wdata), .panel_view(panel_view), .panel_refused(panel_refused),
        .q(q), .count(count), .scaled_value(scaled_value));

    always #4 pclk = ~pclk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task finish_test;
        begin
            $display("checks=%0d errors=%0d", checks, err_count);
            if (err_count == 0 && checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checks++;
            if (got !== exp) begin
                err_count++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= ad;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (pready !== 1'b1 && k < 20);
            if (k >= 20) begin
                err_count++;
                finish_test();
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // pins reach the block through two flops, then wait for the next scans
    task setp(input logic [7:0] p);
        begin
            @(posedge pclk);
            want_pins <= p;
            repeat (3 * SCAN + 4) @(posedge pclk);
        end
    endtask

    task panel(input logic [15:0] d, input logic r);
        begin
            @(posedge pclk);
            panel_wr <= 1'b1;
            panel_wdata <= d;
            @(posedge pclk);
            panel_wr <= 1'b0;
            @(negedge pclk);
            chk({31'h0, panel_refused}, {31'h0, r});
            @(negedge pclk);
            chk({16'h0, panel_view}, r ? 32'h0 : {16'h0, d});
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, panel_wr, want_pwr} = 5'b00001;
        {paddr, pwdata, want_pins, want_ain, panel_wdata} = '0;
        {err_count, checks, exp_cnt} = '0;
        void'($urandom(25));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OFS_CTRL, 0);
        chk(rd, `CTRL_RESET);
        apb(0, `OFS_GAIN, 0);
        chk(rd, 32'h0000_0064);
        apb(0, 8'h24, 0);
        chk({31'h0, err}, 1);
        chk(rd, 0);
        apb(1, `OFS_GAIN, 32'h0000_07d0);
        apb(0, `OFS_GAIN, 0);
        chk(rd, 32'h0000_03e8);
        apb(1, `OFS_OFFSET, 32'hffff_b1e0);
        apb(0, `OFS_OFFSET, 0);
        chk(rd, 32'hffff_d8f0);
        for (n = 0; n < 6; n++) begin
            a = (n == 0) ? 1100 : $urandom % 1001;
            g = $urandom % 2001 - 1000;
            o = $urandom % 20001 - 10000;
            apb(1, `OFS_GAIN, g);
            apb(1, `OFS_OFFSET, o);
            want_ain <= a[15:0];
            setp(8'h00);
            a = (a > 1000) ? 1000 : a;
            o = (a * g) / 100 + o;
            chk(scaled_value, o);
            apb(0, `OFS_SCALED, 0);
            chk(rd, o);
            apb(0, `OFS_INTERNAL, 0);
            chk(rd, a);
        end
        setp(8'h21);
        chk({31'h0, q}, 1);
        setp(8'h61);
        chk({31'h0, q}, 0);
        setp(8'h01);
        chk({31'h0, q}, 0);
        setp(8'h23);
        chk({31'h0, q}, 0);
        setp(8'h20);
        chk({31'h0, q}, 0);
        for (n = 0; n < 8; n++) begin
            setp(n < 5 ? 8'h28 : 8'h38);
            setp(n < 5 ? 8'h20 : 8'h30);
            exp_cnt = (n < 5) ? exp_cnt + 1 : exp_cnt - 1;
            chk({16'h0, count}, exp_cnt);
        end
        setp(8'h08);
        setp(8'h00);
        chk({16'h0, count}, exp_cnt);
        for (n = 0; n < 3; n++) begin
            apb(1, `OFS_CTRL, (n == 0) ? 32'h1 : (n == 1) ? 32'h2 : 32'h0);
            want_pwr <= 1'b0;
            setp(8'h00);
            chk({16'h0, count}, exp_cnt);
            want_pwr <= 1'b1;
            setp(8'h00);
            exp_cnt = (n == 2) ? 0 : exp_cnt;
            chk({16'h0, count}, exp_cnt);
        end
        setp(8'h28);
        setp(8'ha0);
        chk({16'h0, count}, 0);
        apb(1, `OFS_CTRL, 32'h2000);
        setp(8'h01);
        chk({31'h0, q}, 1);
        apb(1, `OFS_CTRL, 32'h08);
        setp(8'h22);
        apb(1, `OFS_TIME, 32'h01ff);
        apb(0, `OFS_TIME, 0);
        chk(rd, 32'h013b);
        apb(1, `OFS_CTRL, 32'h00);
        apb(1, `OFS_TIME, 32'h01ff);
        apb(0, `OFS_TIME, 0);
        chk(rd, 32'h0163);
        apb(1, `OFS_CTRL, 32'h08);
        apb(1, `OFS_TIME, 32'h0002);
        want_pins <= 8'h24;
        // two minute-base units of 100 ticks; scans steal a few ticks
        n = 0;
        while (q !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, n > 200 * TICK - 20 && n < 250 * TICK + 60}, 1);
        if (n >= 3000) finish_test();
        apb(0, `OFS_ELAPSED, 0);
        chk(rd, 32'h2);
        apb(0, `OFS_STATUS, 0);
        chk(rd, 32'h19);
        apb(1, `OFS_CTRL, 32'h04);
        panel(16'h0005, 1'b1);
        apb(0, `OFS_TIME, 0);
        chk(rd, 32'h2);
        apb(1, `OFS_CTRL, 32'h00);
        panel(16'h0105, 1'b0);
        apb(0, `OFS_TIME, 0);
        chk(rd, 32'h0105);
        finish_test();
    end
endmodule
`default_nettype wire
